//--- hdl/input_volume_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// (RULE1) Host leaves level-control tuning fields alone while level control runs.
// (RULE2) Host sets recovery wait code equal to zero-cross timeout code.
// (RULE3) Level control off: each channel uses its own host gain code.
// (RULE4) Gain codes step 0.375 dB, F1 is +36 dB, 91 is 0 dB, 00 mutes.
// (RULE5) New gain applies at channel zero crossing or on timeout.
// (RULE6) Gains written while powered down apply when initialization ends.
// (RULE7) A changed gain write restarts that channel's timeout counter.
// (RULE8) A gain write equal to the previous value is ignored completely.
// (RULE9) Level control on: both channels start from the left gain.
// (RULE10) Gain register writes are dropped while level control is enabled.
// (RULE11) Level control off again: gains return to last host values.
// (RULE12) Host waits over one timeout before re-enabling level control.
// (RULE13) Power-down pin low returns all registers to defaults.
// (RULE14) Power bit rising starts initialization of 3088, 1552 or 784 samples.
// (RULE15) Output words are zero during initialization.
// (RULE16) Frame is chip address, write bit, 5-bit address, 8 data bits.
// (RULE17) Polarity low: chip address 10, select active low, latch at 16th edge.
// (RULE18) Polarity high: chip address 01, select active high, latch at 16th edge.
// (RULE19) Bits sampled on rising serial clock; one register per frame.
// (RULE20) Host keeps serial control clock at or below 7 MHz; the testbench host clocks it with a 12 ns period.
// (RULE21) Host writes only addresses 10 to 1E with fixed reserved values.
// (RULE22) Frames with wrong chip address, wrong write bit or cut short are dropped.
`include "input_digital_gain_cfg.svh"
module input_volume_ctrl #(
    parameter int SAMPLE_WIDTH = 16
) (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic                          power_down_n,
    input  wire logic                          ctrl_serial_clock,
    input  wire logic                          ctrl_select,
    input  wire logic                          ctrl_serial_in,
    input  wire logic                          select_polarity_pin,
    input  wire logic                          sample_tick,
    input  wire logic signed [SAMPLE_WIDTH-1:0] left_sample_in,
    input  wire logic signed [SAMPLE_WIDTH-1:0] right_sample_in,
    output wire logic signed [SAMPLE_WIDTH-1:0] left_sample_out,
    output wire logic signed [SAMPLE_WIDTH-1:0] right_sample_out,
    output wire input_digital_gain_pkg::gain_code_t          left_gain_applied,
    output wire input_digital_gain_pkg::gain_code_t          right_gain_applied,
    output wire input_digital_gain_pkg::gain_db8_t           left_gain_db8,
    output wire input_digital_gain_pkg::gain_db8_t           right_gain_db8,
    output var  logic                          init_busy,
    output var  logic                          auto_level_active
);
    import input_digital_gain_pkg::*;

    if (SAMPLE_WIDTH < 2) begin : g_bad_width
        $error("SAMPLE_WIDTH must be at least 2");
    end

    // Link side

    frame_t rx_frame;
    logic   rx_toggle;

    serial_ctrl_rx u_rx (
        .rstn                (rstn),
        .ctrl_serial_clock   (ctrl_serial_clock),
        .ctrl_select         (ctrl_select),
        .ctrl_serial_in      (ctrl_serial_in),
        .select_polarity_pin (select_polarity_pin),
        .frame               (rx_frame),
        .frame_toggle        (rx_toggle)
    );

    // Crossings into the system clock

    logic toggle_meta;
    logic toggle_sync;
    logic toggle_seen;
    logic pdn_meta;
    logic pdn_sync;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            toggle_meta <= 1'b0;
            toggle_sync <= 1'b0;
            toggle_seen <= 1'b0;
        end else begin
            toggle_meta <= rx_toggle;
            toggle_sync <= toggle_meta;
            toggle_seen <= toggle_sync;
        end
    end

    // Power-down pin synchroniser idles released so only a real low clears
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pdn_meta <= 1'b1;
            pdn_sync <= 1'b1;
        end else begin
            pdn_meta <= power_down_n;
            pdn_sync <= pdn_meta;
        end
    end

    // Frame word is stable long before the toggle arrives here: the host
    // needs at least a full frame of serial clocks to change it again
    wire       pdn_active = !pdn_sync;
    wire       wr         = toggle_sync ^ toggle_seen;
    wire [4:0] wr_addr    = rx_frame.reg_addr;
    wire [7:0] wr_data    = rx_frame.data;

    // Register decode

    logic [1:0]  power_bits;
    logic [1:0]  highpass_init_sel;
    logic [1:0]  zero_cross_timeout_sel;
    logic        auto_level_enable;
    gain_code_t  gain_reg [2];

    wire        wr_power  = wr && (wr_addr == `ADDR_POWER);
    wire        wr_fs     = wr && (wr_addr == `ADDR_FS_SELECT);
    wire        wr_timer  = wr && (wr_addr == `ADDR_TIMER);
    wire        wr_level  = wr && (wr_addr == `ADDR_LEVEL_CTRL);
    wire [1:0]  next_power = wr_data[`POWER_RIGHT_BIT:`POWER_LEFT_BIT];
    wire        power_rise = wr_power && |(next_power & ~power_bits);
    wire        power_off  = wr_power && (next_power == 2'h0);
    wire        next_level = wr_data[`LEVEL_ENABLE_BIT];
    wire        level_flip = wr_level && (next_level != auto_level_enable);
    // Codes above the top step are held at +36 dB
    wire gain_code_t clamped = (wr_data > `GAIN_MAX) ? `GAIN_MAX : wr_data; // (RULE4)

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            power_bits             <= `POWER_RESET;
            highpass_init_sel      <= `SEL_RESET;
            zero_cross_timeout_sel <= `SEL_RESET;
            auto_level_enable      <= 1'b0;
        end else if (pdn_active) begin // (RULE13)
            power_bits             <= `POWER_RESET;
            highpass_init_sel      <= `SEL_RESET;
            zero_cross_timeout_sel <= `SEL_RESET;
            auto_level_enable      <= 1'b0;
        end else begin
            if (wr_power) begin
                power_bits <= next_power;
            end
            if (wr_fs) begin
                highpass_init_sel <= wr_data[`HPF_LSB+1:`HPF_LSB];
            end
            if (wr_timer) begin
                zero_cross_timeout_sel <= wr_data[`ZTM_LSB+1:`ZTM_LSB];
            end
            if (wr_level) begin
                auto_level_enable <= next_level;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            auto_level_active <= 1'b0;
        end else begin
            auto_level_active <= auto_level_enable;
        end
    end

    // Initialization cycle

    conv_state_t state;
    logic [11:0] init_cnt;
    logic [11:0] init_len;

    always_comb begin
        case (highpass_init_sel) // (RULE14)
            2'h1:    init_len = `INIT_LEN_01;
            2'h2:    init_len = `INIT_LEN_10;
            // Code 11 has no defined length; fall back to the longest
            default: init_len = `INIT_LEN_00;
        endcase
    end

    wire init_last = sample_tick && (init_cnt == (init_len - 12'h001));
    wire init_done = (state == ST_INIT) && init_last && !power_rise && !power_off;
    wire run_state = (state == ST_RUN);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state     <= ST_OFF;
            init_cnt  <= 12'h000;
            init_busy <= 1'b0;
        end else if (pdn_active) begin
            state     <= ST_OFF;
            init_cnt  <= 12'h000;
            init_busy <= 1'b0;
        end else begin
            case (state)
                ST_OFF: begin
                    if (power_rise) begin // (RULE14)
                        state     <= ST_INIT;
                        init_busy <= 1'b1;
                    end
                    init_cnt <= 12'h000;
                end
                ST_INIT: begin
                    if (power_off) begin
                        state     <= ST_OFF;
                        init_busy <= 1'b0;
                        init_cnt  <= 12'h000;
                    end else if (power_rise) begin
                        init_cnt <= 12'h000;
                    end else if (init_last) begin
                        state     <= ST_RUN;
                        init_busy <= 1'b0;
                        init_cnt  <= 12'h000;
                    end else if (sample_tick) begin
                        init_cnt <= init_cnt + 12'h001;
                    end
                end
                ST_RUN: begin
                    if (power_off) begin
                        state <= ST_OFF;
                    end else if (power_rise) begin // (RULE14)
                        state     <= ST_INIT;
                        init_busy <= 1'b1;
                    end
                    init_cnt <= 12'h000;
                end
                default: begin
                    state     <= ST_OFF;
                    init_busy <= 1'b0;
                    init_cnt  <= 12'h000;
                end
            endcase
        end
    end

    // Channels

    wire [10:0] timeout_len = 11'(`TMO_BASE << zero_cross_timeout_sel); // (RULE5)

    logic signed [SAMPLE_WIDTH-1:0] sample_in  [2];
    logic signed [SAMPLE_WIDTH-1:0] sample_out [2];
    gain_code_t                     applied    [2];
    gain_db8_t                      gain_db8   [2];

    assign sample_in[0]       = left_sample_in;
    assign sample_in[1]       = right_sample_in;
    assign left_sample_out    = sample_out[0];
    assign right_sample_out   = sample_out[1];
    assign left_gain_applied  = applied[0];
    assign right_gain_applied = applied[1];
    assign left_gain_db8      = gain_db8[0];
    assign right_gain_db8     = gain_db8[1];

    function automatic gain_db8_t to_db8(input gain_code_t code);
        gain_db8_t d;
        d      = $signed({3'h0, code}) - $signed({3'h0, `GAIN_RESET});
        to_db8 = d + d + d;
    endfunction : to_db8

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        localparam logic [4:0] CH_ADDR = 5'(`ADDR_LEFT_GAIN + ch);

        logic [10:0] tmo_cnt;
        logic        prev_sign;

        wire wr_gain   = wr && (wr_addr == CH_ADDR) && !auto_level_enable; // (RULE10)
        wire changed   = wr_gain && (clamped != gain_reg[ch]); // (RULE8)
        // Level control seeds both channels from the left code
        wire gain_code_t target = auto_level_enable ? gain_reg[0] : gain_reg[ch]; // (RULE3) (RULE9) (RULE11)
        wire zero_cross = (sample_in[ch][SAMPLE_WIDTH-1] != prev_sign);
        wire expired    = (tmo_cnt >= timeout_len);
        wire update     = sample_tick && run_state && (target != applied[ch])
                          && (zero_cross || expired); // (RULE5)
        // A mode change restarts the wait so the new target gets a full timeout
        wire restart    = changed || level_flip; // (RULE7)
        wire muted      = init_busy || !power_bits[ch] || (applied[ch] == `GAIN_MUTE);

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                gain_reg[ch]   <= `GAIN_RESET;
                applied[ch]    <= `GAIN_RESET;
                tmo_cnt        <= 11'h000;
                prev_sign      <= 1'b0;
                sample_out[ch] <= '0;
                gain_db8[ch]   <= 11'sh000;
            end else if (pdn_active) begin // (RULE13)
                gain_reg[ch]   <= `GAIN_RESET;
                applied[ch]    <= `GAIN_RESET;
                tmo_cnt        <= 11'h000;
                prev_sign      <= 1'b0;
                sample_out[ch] <= '0;
                gain_db8[ch]   <= to_db8(applied[ch]);
            end else begin
                if (changed) begin
                    gain_reg[ch] <= clamped; // (RULE6)
                end
                if (sample_tick) begin
                    prev_sign <= sample_in[ch][SAMPLE_WIDTH-1];
                end
                if (restart || update) begin
                    tmo_cnt <= 11'h000; // (RULE7)
                end else if (sample_tick && !expired) begin
                    tmo_cnt <= tmo_cnt + 11'h001;
                end
                if (init_done || update) begin
                    applied[ch] <= target; // (RULE6) (RULE5)
                end
                if (sample_tick) begin
                    sample_out[ch] <= muted ? '0 : sample_in[ch]; // (RULE15) (RULE4)
                end
                gain_db8[ch] <= to_db8(applied[ch]); // (RULE4)
            end
        end
    end

endmodule : input_volume_ctrl
`default_nettype wire

//--- hdl/serial_ctrl_rx.sv
`timescale 1ns/10ps
`default_nettype none
`include "input_digital_gain_cfg.svh"
module serial_ctrl_rx (
    input  wire logic       rstn,
    input  wire logic       ctrl_serial_clock,
    input  wire logic       ctrl_select,
    input  wire logic       ctrl_serial_in,
    input  wire logic       select_polarity_pin,
    output var  input_digital_gain_pkg::frame_t frame,
    output var  logic       frame_toggle
);
    import input_digital_gain_pkg::*;

    logic [4:0]  bit_cnt;
    logic [14:0] shift;

    // Select is active when it equals the polarity strap
    wire        cs_active   = (ctrl_select == select_polarity_pin);
    // Counter clears while select is idle, so a short frame leaves nothing behind
    wire        frame_rst_n = rstn & cs_active;
    wire [15:0] word        = {shift, ctrl_serial_in};
    wire [1:0]  chip_expect = select_polarity_pin ? `CHIP_ADDR_POL_HIGH : `CHIP_ADDR_POL_LOW;
    wire        last_bit    = (bit_cnt == 5'(`FRAME_BITS - 5'h01));
    wire        chip_ok     = (word[15:14] == chip_expect) && (word[13] == `WRITE_FLAG);

    always_ff @(posedge ctrl_serial_clock or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt <= 5'h00;
            shift   <= 15'h0000;
        end else if (bit_cnt != `FRAME_BITS) begin // (RULE19)
            shift   <= word[14:0];
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // Word is held until the next good frame; the toggle carries the event across
    always_ff @(posedge ctrl_serial_clock or negedge rstn) begin
        if (!rstn) begin
            frame        <= '0;
            frame_toggle <= 1'b0;
        end else if (cs_active && last_bit && chip_ok) begin // (RULE16) (RULE17) (RULE18) (RULE22)
            frame        <= '{reg_addr: word[12:8], data: word[7:0]};
            frame_toggle <= ~frame_toggle;
        end
    end

endmodule : serial_ctrl_rx
`default_nettype wire

//--- inc/input_digital_gain_cfg.svh
`ifndef INPUT_DIGITAL_GAIN_CFG_SVH
`define INPUT_DIGITAL_GAIN_CFG_SVH

// Register offsets on the serial control port
`define ADDR_POWER        5'h10
`define ADDR_FS_SELECT    5'h15
`define ADDR_LEFT_GAIN    5'h18
`define ADDR_RIGHT_GAIN   5'h19
`define ADDR_TIMER        5'h1A
`define ADDR_LEVEL_CTRL   5'h1C

// Field positions
`define POWER_LEFT_BIT    0
`define POWER_RIGHT_BIT   1
`define HPF_LSB           6
`define ZTM_LSB           2
`define LEVEL_ENABLE_BIT  7

// Reset values, gain ceiling and mute code
`define GAIN_RESET        8'h91
`define GAIN_MAX          8'hF1
`define GAIN_MUTE         8'h00
`define POWER_RESET       2'h0
`define SEL_RESET         2'h0

// Frame layout
`define FRAME_BITS        5'h10
`define CHIP_ADDR_POL_LOW  2'h2
`define CHIP_ADDR_POL_HIGH 2'h1
`define WRITE_FLAG        1'h1

// Timing counts in sample periods (1/fs)
`define TMO_BASE          11'h080
`define INIT_LEN_00       12'hC10
`define INIT_LEN_01       12'h610
`define INIT_LEN_10       12'h310

`endif

//--- inc/input_digital_gain_pkg.sv
package input_digital_gain_pkg;

    typedef logic [7:0] gain_code_t;

    typedef logic signed [10:0] gain_db8_t;

    typedef struct packed {
        logic [4:0] reg_addr;
        logic [7:0] data;
    } frame_t;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_INIT = 3'b010,
        ST_RUN  = 3'b100
    } conv_state_t;

endpackage : input_digital_gain_pkg

//--- sim/input_digital_gain_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module input_digital_gain_assertions #(parameter int SAMPLE_WIDTH = 16) (
    input wire logic                            clk,
    input wire logic                            rstn,
    input wire logic                            power_down_n,
    input wire logic                            sample_tick,
    input wire logic signed [SAMPLE_WIDTH-1:0]  left_sample_out,
    input wire logic signed [SAMPLE_WIDTH-1:0]  right_sample_out,
    input wire input_digital_gain_pkg::gain_code_t            left_gain_applied,
    input wire input_digital_gain_pkg::gain_code_t            right_gain_applied,
    input wire input_digital_gain_pkg::gain_db8_t             left_gain_db8,
    input wire logic                            init_busy,
    input wire logic                            auto_level_active
);
    import input_digital_gain_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [11:0] init_ticks;
    // Ticks of one init cycle, judged when busy drops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            init_ticks <= '0;
        else if (!init_busy)
            init_ticks <= '0;
        else if (sample_tick)
            init_ticks <= init_ticks + 12'h001;
    end
    property p_db8;
        1'b1 |=> left_gain_db8 == gain_db8_t'(3 * (int'($past(left_gain_applied)) - 145));
    endproperty
    a_db8: assert property (p_db8) else $error("left dB value wrong");
    property p_mute;
        $past(sample_tick) && right_gain_applied == 8'h00 && $past(right_gain_applied) == 8'h00
            |-> right_sample_out == '0;
    endproperty
    a_mute: assert property (p_mute) else $error("muted channel not zero");
    property p_init_zero;
        init_busy && $past(init_busy) && $past(sample_tick)
            |-> left_sample_out == '0 && right_sample_out == '0;
    endproperty
    a_init_zero: assert property (p_init_zero) else $error("output during init");
    property p_init_hold;
        init_busy && $past(init_busy) |-> $stable(left_gain_applied) && $stable(right_gain_applied);
    endproperty
    a_init_hold: assert property (p_init_hold) else $error("gain moved in init");
    property p_tick_only;
        $changed(left_gain_applied) && power_down_n
            |-> $past(sample_tick) || $past(init_busy) || $past(init_busy, 2);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("gain moved off tick");
    property p_level_equal;
        auto_level_active && $past(auto_level_active)
            && $past(left_gain_applied) == $past(right_gain_applied)
            |-> left_gain_applied == right_gain_applied;
    endproperty
    a_level_equal: assert property (p_level_equal) else $error("channels split");
    property p_level_start;
        $rose(auto_level_active) |-> ##[1:700] left_gain_applied == right_gain_applied;
    endproperty
    a_level_start: assert property (p_level_start) else $error("no common start");
    property p_pdn;
        (!power_down_n) [*5] |-> left_gain_applied == 8'h91 && right_gain_applied == 8'h91
            && !init_busy && !auto_level_active;
    endproperty
    a_pdn: assert property (p_pdn) else $error("power down not cleared");
    property p_init_len;
        $fell(init_busy) |-> init_ticks inside {[783:785], [1551:1553], [3087:3089]};
    endproperty
    a_init_len: assert property (p_init_len) else $error("init length wrong");
    c_init: cover property ($fell(init_busy));
    c_level: cover property ($rose(auto_level_active));
    c_mute: cover property (right_gain_applied == 8'h00 && $past(sample_tick));
endmodule : input_digital_gain_assertions
bind input_volume_ctrl input_digital_gain_assertions #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) u_chk (
    .clk(clk), .rstn(rstn), .power_down_n(power_down_n), .sample_tick(sample_tick),
    .left_sample_out(left_sample_out), .right_sample_out(right_sample_out),
    .left_gain_applied(left_gain_applied), .right_gain_applied(right_gain_applied),
    .left_gain_db8(left_gain_db8), .init_busy(init_busy),
    .auto_level_active(auto_level_active));
`default_nettype wire

//--- sim/serial_host.sv
`timescale 1ns/10ps
`default_nettype none
module serial_host (
    input  wire logic select_polarity_pin,
    output wire logic ctrl_select,
    output var  logic ctrl_serial_clock,
    output var  logic ctrl_serial_in
);
    logic sel_on = 1'b0;
    assign ctrl_select = sel_on ~^ select_polarity_pin;
    initial begin
        ctrl_serial_clock = 1'b0;
        ctrl_serial_in = 1'b0;
    end
    // Clock stands low between frames; released data shows the inverse bit
    task automatic send(input logic [15:0] word, input int nbits);
        sel_on = 1'b1;
        for (int i = 15; i > 15 - nbits; i--) begin
            ctrl_serial_in = word[i];
            #6 ctrl_serial_clock = 1'b1;
            #6 ctrl_serial_clock = 1'b0;
        end
        #6 sel_on = 1'b0;
        ctrl_serial_in = ~ctrl_serial_in;
        #30;
    endtask : send
endmodule : serial_host
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import input_digital_gain_pkg::*;
    logic clk, rstn, power_down_n, select_polarity_pin, sample_tick;
    logic ctrl_serial_clock, ctrl_select, ctrl_serial_in, init_busy, auto_level_active;
    logic signed [15:0] left_sample_in, right_sample_in, left_sample_out, right_sample_out;
    gain_code_t left_gain_applied, right_gain_applied, last_l, last_r, g;
    gain_db8_t  left_gain_db8, right_gain_db8;
    gain_code_t exp_l[$], exp_r[$];
    int miscompares = 0, checks = 0, n, len;
    logic [31:0] lfsr_state = 32'h5F7F;
    logic [31:0] gain_tbl = 32'h91F10040, prev_tbl = 32'h004058A0;
    logic zc = 1'b0, sgn = 1'b0;

    input_volume_ctrl #(.SAMPLE_WIDTH(16)) u_dut (
        .clk(clk), .rstn(rstn), .power_down_n(power_down_n),
        .ctrl_serial_clock(ctrl_serial_clock), .ctrl_select(ctrl_select),
        .ctrl_serial_in(ctrl_serial_in), .select_polarity_pin(select_polarity_pin),
        .sample_tick(sample_tick), .left_sample_in(left_sample_in),
        .right_sample_in(right_sample_in), .left_sample_out(left_sample_out),
        .right_sample_out(right_sample_out), .left_gain_applied(left_gain_applied),
        .right_gain_applied(right_gain_applied), .left_gain_db8(left_gain_db8),
        .right_gain_db8(right_gain_db8), .init_busy(init_busy),
        .auto_level_active(auto_level_active));
    serial_host u_host (.select_polarity_pin(select_polarity_pin), .ctrl_select(ctrl_select),
        .ctrl_serial_clock(ctrl_serial_clock), .ctrl_serial_in(ctrl_serial_in));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, want, seen);
        end
    endtask : check
    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        u_host.send({select_polarity_pin ? 2'h1 : 2'h2, 1'b1, addr, data}, 16);
        repeat (6) @(posedge clk);
    endtask : wr
    task automatic set_gain(input logic ch, input gain_code_t v);
        if (ch) begin
            exp_r.push_back(v);
        end else begin
            exp_l.push_back(v);
        end
        wr(ch ? 5'h19 : 5'h18, v);
    endtask : set_gain
    task automatic wait_ticks(input int k);
        repeat (k) @(posedge sample_tick);
    endtask : wait_ticks
    task automatic final_report;
        check("queue", 16'(exp_l.size() + exp_r.size()), 16'h0000);
        $display("Checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Sign flips every sample only when crossings are wanted
    initial begin
        sample_tick = 1'b0;
        left_sample_in = '0;
        right_sample_in = '0;
        forever begin
            repeat (3) @(posedge clk);
            #1 sample_tick = 1'b1;
            lfsr_state = lfsr(lfsr_state);
            sgn = zc & ~sgn;
            left_sample_in = {sgn, lfsr_state[14:0]};
            right_sample_in = {sgn, lfsr_state[30:16]};
            @(posedge clk);
            #1 sample_tick = 1'b0;
        end
    end
    initial begin
        @(posedge rstn);
        last_l = 8'h91;
        last_r = 8'h91;
        forever begin
            @(posedge clk);
            #2;
            if (left_gain_applied !== last_l) begin
                check("left_gain", left_gain_applied, exp_l.size() ? exp_l.pop_front() : 8'hXX);
                last_l = left_gain_applied;
            end
            if (right_gain_applied !== last_r) begin
                check("right_gain", right_gain_applied, exp_r.size() ? exp_r.pop_front() : 8'hXX);
                last_r = right_gain_applied;
            end
        end
    end
    initial begin
        repeat (80000) @(posedge clk);
        miscompares++;
        final_report();
    end

    initial begin
        rstn = 1'b0;
        power_down_n = 1'b1;
        select_polarity_pin = 1'b0;
        repeat (6) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (2) @(posedge clk);
        check("reset_gain", {left_gain_applied, right_gain_applied}, 16'h9191);
        set_gain(0, 8'hA0);
        set_gain(1, 8'h58);
        for (int i = 0; i < 3; i++) begin
            wr(5'h10, 8'h00);
            wr(5'h15, 8'(2 - i) << 6);
            wr(5'h10, 8'h03);
            len = (i == 0) ? 784 : (i == 1) ? 1552 : 3088;
            check("init_busy", 16'(init_busy), 16'h0001);
            n = 0;
            while (init_busy === 1'b1 && n < 4000) begin
                @(posedge sample_tick);
                n++;
            end
            check("init_len", 16'(n >= len - 4 && n <= len + 1), 16'h0001);
        end
        $display("done init");
        for (int z = 0; z < 4; z++) begin
            wr(5'h1A, 8'(z * 5));
            g = gain_tbl[8*z +: 8];
            set_gain(z[0], g);
            wait_ticks((128 << z) - 6);
            check("early", z[0] ? right_gain_applied : left_gain_applied, prev_tbl[8*z +: 8]);
            wait_ticks(12);
            check("timeout", z[0] ? right_gain_applied : left_gain_applied, g);
        end
        wr(5'h1A, 8'h00);
        $display("done timeout");
        wr(5'h18, 8'hC0);
        wait_ticks(100);
        set_gain(0, 8'hC1);
        wait_ticks(100);
        check("restart", left_gain_applied, 8'hF1);
        wait_ticks(40);
        check("restart_end", left_gain_applied, 8'hC1);
        set_gain(0, 8'hD0);
        wait_ticks(100);
        wr(5'h18, 8'hD0);
        wait_ticks(40);
        check("same_value", left_gain_applied, 8'hD0);
        $display("done restart");
        zc = 1'b1;
        u_host.send({2'h1, 1'b1, 5'h18, 8'h11}, 16);
        u_host.send({2'h2, 1'b0, 5'h18, 8'h22}, 16);
        u_host.send({2'h2, 1'b1, 5'h18, 8'h33}, 10);
        wait_ticks(8);
        check("refused", left_gain_applied, 8'hD0);
        set_gain(0, 8'hE1);
        set_gain(1, 8'hC6);
        wait_ticks(4);
        check("zero_cross", {left_gain_applied, right_gain_applied}, 16'hE1C6);
        exp_r.push_back(8'hE1);
        wr(5'h1C, 8'h80);
        wait_ticks(4);
        check("level_start", right_gain_applied, 8'hE1);
        wr(5'h18, 8'h30);
        wr(5'h19, 8'h20);
        wait_ticks(4);
        exp_r.push_back(8'hC6);
        wr(5'h1C, 8'h00);
        wait_ticks(4);
        check("level_off", {left_gain_applied, right_gain_applied}, 16'hE1C6);
        check("right_db8", 16'(right_gain_db8), 16'h009F);
        $display("done level");
        exp_l.push_back(8'h91);
        exp_r.push_back(8'h91);
        @(posedge clk);
        #1 power_down_n = 1'b0;
        repeat (6) @(posedge clk);
        #1 power_down_n = 1'b1;
        repeat (6) @(posedge clk);
        check("pdn_gain", {left_gain_applied, right_gain_applied}, 16'h9191);
        check("pdn_flags", {init_busy, auto_level_active}, 16'h0000);
        #1 select_polarity_pin = 1'b1;
        rstn = 1'b0;
        repeat (6) @(posedge clk);
        #1 rstn = 1'b1;
        set_gain(0, 8'hA5);
        u_host.send({2'h2, 1'b1, 5'h18, 8'h77}, 16);
        wr(5'h15, 8'h80);
        wr(5'h10, 8'h01);
        wait_ticks(800);
        check("polarity_high", left_gain_applied, 8'hA5);
        $display("done polarity");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
